// ---- rtl/asr_pkg.sv ----
// Package: constants and types for the asynchronous serial receiver
package asr_pkg;

  // Sixteen samples per bit time
  localparam int unsigned OVERSAMPLE = 16;
  localparam logic [3:0] HALF_BIT = 4'h7;
  localparam logic [3:0] FULL_BIT = 4'hF;
  localparam int unsigned FIFO_DEPTH = 2;

  // Register offsets on the plain register port
  localparam logic [3:0] REG_RX_DATA = 4'h0;
  localparam logic [3:0] REG_RX_CTRL = 4'h1;
  localparam logic [3:0] REG_BAUD_DIV = 4'h2;
  localparam logic [3:0] REG_INT_STAT = 4'h3;
  localparam logic [3:0] REG_INT_MASK = 4'h4;
  localparam logic [3:0] REG_RX_STAT = 4'h5;

  // Control register bit positions
  localparam int unsigned CTL_SERIAL_PORT_ENABLE = 0;
  localparam int unsigned CTL_CONTINUOUS_RECEIVE_ENABLE = 1;
  localparam int unsigned CTL_SYNC = 2;
  localparam int unsigned CTL_NINE = 3;
  localparam int unsigned CTL_RX_INTERRUPT_ENABLE = 4;
  localparam int unsigned CTL_PERIPHERAL_INTERRUPT_ENABLE = 5;
  localparam int unsigned CTL_GIE = 6;
  localparam logic [7:0] CTL_RESET = 8'h00;

  // Status bit positions (pending, framing of head, overrun)
  localparam int unsigned ST_PEND = 0;
  localparam int unsigned ST_FERR = 1;
  localparam int unsigned ST_OERR = 2;

  // Event bits: char received, framing error, overrun
  localparam int unsigned EV_RX = 0;
  localparam int unsigned EV_FERR = 1;
  localparam int unsigned EV_OERR = 2;

  localparam logic [15:0] BAUD_DIV_RESET = 16'h0000;

  typedef enum logic [1:0] {
    ASR_IDLE,
    ASR_START,
    ASR_DATA,
    ASR_STOP
  } asr_state_t;

  typedef struct packed {
    logic ferr;
    logic [8:0] data;
  } asr_entry_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } asr_bus_req_t;

  typedef struct packed {
    asr_state_t st;
    logic [2:0] rx_sync;
    logic rx_prev;
    logic [15:0] div_cnt;
    logic [3:0] tick_cnt;
    logic [2:0] votes;
    logic [3:0] bit_idx;
    logic [8:0] shift;
    asr_entry_t [1:0] fifo;
    logic [1:0] count;
    logic rd_ptr;
    logic oerr;
    logic [7:0] ctrl;
    logic [15:0] baud_div;
    logic [2:0] int_stat;
    logic [2:0] int_mask;
    logic [15:0] rdata;
  } asr_state_all_t;

endpackage

// ---- rtl/asr_receiver.sv ----
// Asynchronous serial receiver: data recovery, shift register, two-entry FIFO
`timescale 1ns/1ps

module asr_receiver (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Receive line pin
  input wire logic receive_line_pin_in,
  output logic receive_line_pin_oe_n,
  // Transmit line pin
  input wire logic tx_line_drive,
  input wire logic tx_dir_latch_in,
  input wire logic tx_port_latch,
  output logic transmit_line_pin_out,
  output logic transmit_line_pin_oe_n,
  // Receive pin general-purpose direction latch
  input wire logic rx_dir_latch_in,
  input wire logic rx_port_latch,
  output logic receive_line_pin_out,
  // Interrupt
  output logic irq
);

  asr_pkg::asr_state_all_t s_q, s_d;
  asr_pkg::asr_bus_req_t req;

  logic serial_port_enable, continuous_receive_enable, rx_on, tick, rx_s, vote, push, pop, full;
  asr_pkg::asr_entry_t head;

  // Majority of three samples
  function automatic logic maj3(input logic [2:0] v);
    maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign serial_port_enable = s_q.ctrl[asr_pkg::CTL_SERIAL_PORT_ENABLE];
  assign continuous_receive_enable = s_q.ctrl[asr_pkg::CTL_CONTINUOUS_RECEIVE_ENABLE];
  assign rx_on = serial_port_enable & continuous_receive_enable & ~s_q.ctrl[asr_pkg::CTL_SYNC];
  // Second synchroniser stage only; third is never read by logic
  assign rx_s = s_q.rx_sync[1];
  assign head = s_q.fifo[s_q.rd_ptr];
  assign full = (s_q.count == 2'(asr_pkg::FIFO_DEPTH));

  assign tick = rx_on && (s_q.div_cnt == s_q.baud_div);

  assign receive_line_pin_oe_n = serial_port_enable ? 1'b1 : rx_dir_latch_in;
  assign receive_line_pin_out = rx_port_latch;
  assign transmit_line_pin_oe_n = serial_port_enable ? 1'b0 : tx_dir_latch_in;
  assign transmit_line_pin_out = serial_port_enable ? tx_line_drive : tx_port_latch;

  assign irq = s_q.ctrl[asr_pkg::CTL_GIE] & s_q.ctrl[asr_pkg::CTL_PERIPHERAL_INTERRUPT_ENABLE] &
               ((s_q.ctrl[asr_pkg::CTL_RX_INTERRUPT_ENABLE] & (s_q.count != 2'h0) & rx_on) |
                (|(s_q.int_stat & s_q.int_mask)));

  assign reg_rdata = s_q.rdata;

  always_comb begin
    s_d = s_q;
    push = 1'b0;
    pop = 1'b0;
    vote = 1'b0;
    s_d.rdata = 16'h0000;
    s_d.rx_sync = {s_q.rx_sync[1:0], receive_line_pin_in};
    // Data taken from the synchronised level, not the raw pin
    s_d.rx_prev = rx_s;

    // Divider restarts each tick so ticks stay evenly spaced
    if (!rx_on || tick) begin
      s_d.div_cnt = 16'h0000;
    end else begin
      s_d.div_cnt = s_q.div_cnt + 16'h0001;
    end

    case (s_q.st)
      asr_pkg::ASR_IDLE: begin
        if (rx_on && !s_q.oerr && s_q.rx_prev && !rx_s) begin
          s_d.st = asr_pkg::ASR_START;
          s_d.tick_cnt = 4'h0;
          s_d.div_cnt = 16'h0000;
        end
      end
      asr_pkg::ASR_START: begin
        if (tick) begin
          s_d.tick_cnt = s_q.tick_cnt + 4'h1;
          if (s_q.tick_cnt == asr_pkg::HALF_BIT) begin
            s_d.tick_cnt = 4'h0;
            s_d.bit_idx = 4'h0;
            s_d.st = rx_s ? asr_pkg::ASR_IDLE : asr_pkg::ASR_DATA;
          end
        end
      end
      asr_pkg::ASR_DATA, asr_pkg::ASR_STOP: begin
        if (tick) begin
          s_d.tick_cnt = s_q.tick_cnt + 4'h1;
          // Three votes just before and at the bit centre
          if (s_q.tick_cnt >= asr_pkg::FULL_BIT - 4'h2) begin
            s_d.votes = {s_q.votes[1:0], rx_s};
          end
          if (s_q.tick_cnt == asr_pkg::FULL_BIT) begin
            s_d.tick_cnt = 4'h0;
            vote = maj3({s_q.votes[1:0], rx_s});
            if (s_q.st == asr_pkg::ASR_DATA) begin
              // Majority bit into shift register, LSB first
              s_d.shift = {vote, s_q.shift[8:1]};
              s_d.bit_idx = s_q.bit_idx + 4'h1;
              if (s_q.bit_idx == (s_q.ctrl[asr_pkg::CTL_NINE] ? 4'h8 : 4'h7)) begin
                s_d.st = asr_pkg::ASR_STOP;
              end
            end else begin
              push = 1'b1;
              s_d.st = asr_pkg::ASR_IDLE;
            end
          end
        end
      end
      default: s_d.st = asr_pkg::ASR_IDLE;
    endcase

    // Register reads; data read pops the FIFO
    if (req.rd) begin
      case (req.addr)
        asr_pkg::REG_RX_DATA: begin
          s_d.rdata = {7'h00, head.data};
          pop = (s_q.count != 2'h0);
        end
        asr_pkg::REG_RX_CTRL: s_d.rdata = {8'h00, s_q.ctrl};
        asr_pkg::REG_BAUD_DIV: s_d.rdata = s_q.baud_div;
        asr_pkg::REG_INT_STAT: s_d.rdata = {13'h0000, s_q.int_stat};
        asr_pkg::REG_INT_MASK: s_d.rdata = {13'h0000, s_q.int_mask};
        // Pending flag from FIFO non-empty, gated by rx_on
        asr_pkg::REG_RX_STAT: s_d.rdata = {13'h0000, s_q.oerr,
                                           head.ferr & (s_q.count != 2'h0),
                                           rx_on & (s_q.count != 2'h0)};
        default: s_d.rdata = 16'h0000;
      endcase
      if (req.addr == asr_pkg::REG_INT_STAT) begin
        s_d.int_stat = 3'h0;
      end
    end

    if (req.wr) begin
      case (req.addr)
        asr_pkg::REG_RX_CTRL: s_d.ctrl = req.wdata[7:0];
        asr_pkg::REG_BAUD_DIV: s_d.baud_div = req.wdata;
        asr_pkg::REG_INT_MASK: s_d.int_mask = req.wdata[2:0];
        default: ;
      endcase
    end

    if (pop) begin
      s_d.rd_ptr = ~s_q.rd_ptr;
    end
    if (push) begin
      // Full FIFO with no read this cycle drops character, flags overrun
      if (full && !pop) begin
        s_d.oerr = 1'b1;
        s_d.int_stat[asr_pkg::EV_OERR] = 1'b1;
      end else begin
        // Character into FIFO with its framing flag
        // Framing error kept per entry
        // Nine-bit mode fills all of the shift register; eight-bit sits in the top bits
        s_d.fifo[s_q.rd_ptr ^ s_q.count[0]] = '{ferr: ~vote, data: s_q.ctrl[asr_pkg::CTL_NINE] ?
                                               s_q.shift : {1'b0, s_q.shift[8:1]}};
        s_d.int_stat[asr_pkg::EV_RX] = 1'b1;
        if (!vote) begin
          s_d.int_stat[asr_pkg::EV_FERR] = 1'b1;
        end
      end
    end
    if (!(push && full && !pop)) begin
      s_d.count = s_q.count + 2'(push) - 2'(pop);
    end else begin
      s_d.count = s_q.count - 2'(pop);
    end

    // Receive enable low clears overrun and goes idle
    if (!continuous_receive_enable) begin
      s_d.oerr = 1'b0;
      s_d.st = asr_pkg::ASR_IDLE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_q <= '0;
      s_q.rx_sync <= 3'h7;
      s_q.rx_prev <= 1'b1;
      s_q.st <= asr_pkg::ASR_IDLE;
      s_q.ctrl <= asr_pkg::CTL_RESET;
      s_q.baud_div <= asr_pkg::BAUD_DIV_RESET;
    end else begin
      s_q <= s_d;
    end
  end

endmodule // asr_receiver

// ---- tb/asr_receiver_chk.sv ----
// Checker: pin, bus and interrupt relations of the receiver
`timescale 1ns/1ps
module asr_receiver_chk (
  // Clock, reset, register port
  input wire logic core_clk, srst, reg_wr, reg_rd,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata, reg_rdata,
  // Pins and interrupt
  input wire logic receive_line_pin_oe_n, receive_line_pin_out, rx_dir_latch_in, rx_port_latch,
  input wire logic tx_line_drive, tx_port_latch, tx_dir_latch_in,
  input wire logic transmit_line_pin_out, transmit_line_pin_oe_n, irq
);
  logic [7:0] ctl_q;
  // Mirror of control, so pin rules can be judged from the ports alone
  always_ff @(posedge core_clk) begin
    if (srst) ctl_q <= 8'h00;
    else if (reg_wr && reg_addr == asr_pkg::REG_RX_CTRL) ctl_q <= reg_wdata[7:0];
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  property p_rx_in; ctl_q[0] |-> receive_line_pin_oe_n; endproperty
  a_rx_in: assert property (p_rx_in) else $error("rx pin driven");
  property p_rx_gp;
    !ctl_q[0] |-> receive_line_pin_oe_n == rx_dir_latch_in && receive_line_pin_out == rx_port_latch;
  endproperty
  a_rx_gp: assert property (p_rx_gp) else $error("rx pin latch");
  property p_tx_out;
    ctl_q[0] |-> !transmit_line_pin_oe_n && transmit_line_pin_out == tx_line_drive;
  endproperty
  a_tx_out: assert property (p_tx_out) else $error("tx pin not serial");
  property p_tx_gp;
    !ctl_q[0] |-> transmit_line_pin_out == tx_port_latch && transmit_line_pin_oe_n == tx_dir_latch_in;
  endproperty
  a_tx_gp: assert property (p_tx_gp) else $error("tx pin latch");
  property p_rd_slot; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
  a_rd_slot: assert property (p_rd_slot) else $error("read data out of slot");
  property p_unmap; $past(reg_rd) && $past(reg_addr) > 4'h5 |-> reg_rdata == 16'h0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_irq_en; irq |-> ctl_q[6] && ctl_q[5]; endproperty
  a_irq_en: assert property (p_irq_en) else $error("irq without enables");
  property p_rst; $fell(srst) |-> !irq && reg_rdata == 16'h0000; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
endmodule // asr_receiver_chk

// ---- tb/asr_tx_model.sv ----
// Remote serial transmitter driving the receive line
`timescale 1ns/1ps
module asr_tx_model (
  // Clock and line
  input wire logic core_clk,
  output logic line
);
  initial line = 1'b1;
  // One bit is 16 clocks at divisor 0; a short start gives a glitch
  task automatic send(input logic [8:0] d, input int nb, input logic stop, input int slen);
    line <= 1'b0;
    repeat (slen) @(posedge core_clk);
    if (slen == 16) begin
      for (int i = 0; i < nb; i++) begin
        line <= d[i];
        repeat (16) @(posedge core_clk);
      end
      line <= stop;
      repeat (16) @(posedge core_clk);
    end
    line <= 1'b1;
    repeat (16) @(posedge core_clk);
  endtask
endmodule // asr_tx_model

// ---- tb/asr_receiver_bench.sv ----
// Bench: register-level tests of the serial receiver
`timescale 1ns/1ps
module asr_receiver_bench;
  logic core_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic [4:0] pins = 5'h00;
  logic [8:0] d;
  logic rx_line, irq, rx_oe_n, rx_out, tx_out, tx_oe_n;
  int n_errors = 0, n_checks = 0;
  localparam logic [3:0] D = asr_pkg::REG_RX_DATA, C = asr_pkg::REG_RX_CTRL;
  localparam logic [3:0] I = asr_pkg::REG_INT_STAT, S = asr_pkg::REG_RX_STAT;
  localparam logic [15:0] P = 16'h0001 << asr_pkg::ST_PEND, F = 16'h0001 << asr_pkg::ST_FERR;
  localparam logic [15:0] O = 16'h0001 << asr_pkg::ST_OERR, EV = 16'h0001 << asr_pkg::EV_RX;
  localparam logic [15:0] EF = 16'h0001 << asr_pkg::EV_FERR, ON = 16'h0001 << asr_pkg::CTL_SERIAL_PORT_ENABLE;
  localparam logic [15:0] CR = 16'h0001 << asr_pkg::CTL_CONTINUOUS_RECEIVE_ENABLE, RI = 16'h0001 << asr_pkg::CTL_RX_INTERRUPT_ENABLE;
  localparam logic [15:0] PG = 16'h0001 << asr_pkg::CTL_PERIPHERAL_INTERRUPT_ENABLE | 16'h0001 << asr_pkg::CTL_GIE;
  asr_tx_model i_tx (.core_clk(core_clk), .line(rx_line));
  asr_receiver i_dut (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .receive_line_pin_in(rx_line), .receive_line_pin_oe_n(rx_oe_n),
    .tx_line_drive(pins[0]), .tx_dir_latch_in(pins[1]), .tx_port_latch(pins[2]),
    .transmit_line_pin_out(tx_out), .transmit_line_pin_oe_n(tx_oe_n),
    .rx_dir_latch_in(pins[3]), .rx_port_latch(pins[4]), .receive_line_pin_out(rx_out),
    .irq(irq));
  initial forever #12.5 core_clk = ~core_clk;
  // Counting pattern keeps every general latch path moving
  always @(posedge core_clk) pins <= pins + 5'h01;
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input string nm, input logic [15:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(nm, reg_rdata, exp);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    wr(S, 16'hFFFF);
    rd(C, "ctrl", 16'h0000);
    rd(S, "status", 16'h0000);
    rd(4'hF, "unmapped", 16'h0000);
    $display("test reset done");
    wr(C, ON | CR | RI | PG);
    i_tx.send(9'h0A5, 8, 1'b1, 16);
    rd(S, "pend", P);
    chk("irq", {15'h0000, irq}, 16'h0001);
    rd(D, "data", 16'h00A5);
    rd(S, "empty", 16'h0000);
    rd(I, "event", EV);
    rd(I, "event clear", 16'h0000);
    i_tx.send(9'h000, 8, 1'b1, 4);
    rd(S, "glitch", 16'h0000);
    rd(I, "glitch event", 16'h0000);
    $display("test receive done");
    wr(C, ON | CR | PG);
    i_tx.send(9'h03C, 8, 1'b0, 16);
    chk("irq masked", {15'h0000, irq}, 16'h0000);
    wr(asr_pkg::REG_INT_MASK, EF);
    chk("irq unmasked", {15'h0000, irq}, 16'h0001);
    rd(S, "ferr", P | F);
    rd(I, "ferr event", EV | EF);
    chk("irq cleared", {15'h0000, irq}, 16'h0000);
    rd(D, "ferr data", 16'h003C);
    $display("test framing done");
    for (d = 9'h011; d < 9'h044; d += 9'h011) i_tx.send(d, 8, 1'b1, 16);
    rd(S, "overrun", P | O);
    rd(D, "first", 16'h0011);
    rd(D, "second", 16'h0022);
    i_tx.send(9'h044, 8, 1'b1, 16);
    rd(S, "blocked", O);
    wr(C, ON | PG);
    wr(C, ON | CR | PG);
    rd(S, "recovered", 16'h0000);
    wr(C, ON | CR | PG | 16'h0001 << asr_pkg::CTL_NINE);
    i_tx.send(9'h1A5, 9, 1'b1, 16);
    rd(D, "nine bit", 16'h01A5);
    $display("test overrun done");
    results();
  end
  initial begin
    repeat (10000) @(posedge core_clk);
    n_errors++;
    results();
  end
endmodule // asr_receiver_bench
bind asr_receiver asr_receiver_chk i_chk (.core_clk, .srst, .reg_wr, .reg_rd, .reg_addr,
  .reg_wdata, .reg_rdata, .receive_line_pin_oe_n, .receive_line_pin_out, .rx_dir_latch_in,
  .rx_port_latch, .tx_line_drive, .tx_port_latch, .tx_dir_latch_in, .transmit_line_pin_out,
  .transmit_line_pin_oe_n, .irq);
